// ==== src/ppb_pkg.sv ====
// package for the page protection bit access block
package ppb_pkg;
    // ************************************************************
    // geometry
    // ************************************************************
    localparam int unsigned PAGE_BYTES  = 32;
    localparam int unsigned PAGE_COUNT  = 256;
    localparam int unsigned ADDR_W      = 13;
    localparam int unsigned PAGE_W      = 8;
    localparam int unsigned OFFS_W      = 5;
    // ************************************************************
    // select byte and control byte codes
    // ************************************************************
    localparam logic [3:0] SELECT_ID        = 4'hA;
    localparam logic [1:0] PROTECT_QUERY    = 2'h0;
    localparam logic [1:0] PROTECT_SET      = 2'h1;
    localparam logic [1:0] PROTECT_CLEAR    = 2'h3;
    localparam logic       PROT_RESET_VALUE = 1'b1;
    // ************************************************************
    // timing: 25 MHz core clock
    // ************************************************************
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned PROG_TIME_US    = 4000;
    localparam int unsigned PROG_CYCLES     = PROG_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned PROG_CNT_W      = 17;

    // bus pin group, sda is open drain: oe low means pulled low
    typedef struct packed {
        logic scl;
        logic sda;
    } ppb_bus_type;

    // one normal-write data request towards the array
    typedef struct packed {
        logic               valid;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         data;
    } ppb_write_type;
endpackage

// ==== src/ppb_top.sv ====
// protection bit path of a two-wire serial eeprom: set, clear, read of page bits
// How it works
// - change bit only after reference matched
// - page data untouched by bit change
// - acknowledge each matching reference byte
// - stop after last byte starts programming
// - program only if all 256 bits matched
// - address counter left at page top
// - bit programming finishes within 4 ms
// - protection bit returned in byte msb
// - bit one allows writes, zero blocks
// - master ack gives next page, nack ends
// - page counter wraps after last page
// - control decoded from two low bits
// - no select ack while programming
// - writes to protected page suppressed
module ppb_top
    import ppb_pkg::*;
(
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_b_i,
    input  wire ppb_pkg::ppb_bus_type     bus_i,
    input  wire logic [2:0]               chip_sel_i,
    input  wire logic [7:0]               page_data_i,
    input  wire ppb_pkg::ppb_write_type   write_req_i,
    output logic                          sda_o,
    output logic                          sda_oe_b_o,
    output logic [ppb_pkg::ADDR_W-1:0]    array_addr_o,
    output logic                          array_write_o,
    output logic [7:0]                    array_data_o,
    output logic                          busy_o
);
    import ppb_pkg::*;

    // ************************************************************
    // pin synchronisers and edge finding
    // ************************************************************
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    logic [2:0] chip_sel_meta;
    logic [2:0] chip_sel_s;
    always_ff @(posedge core_clk_i) begin
        chip_sel_meta <= chip_sel_i;
        chip_sel_s    <= chip_sel_meta;
        scl_sync <= {scl_sync[0], bus_i.scl};
        sda_sync <= {sda_sync[0], bus_i.sda};
        scl_q    <= scl_sync[1];
        sda_q    <= sda_sync[1];
    end
    wire scl_rise   = scl_sync[1] & ~scl_q;
    wire scl_fall   = ~scl_sync[1] & scl_q;
    wire start_seen = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
    wire stop_seen  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

    // ************************************************************
    // protocol state
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_SELECT, ST_ADDR_HI, ST_ADDR_LO, ST_CONTROL,
        ST_REFERENCE, ST_QUERY_ACK, ST_READ_OUT, ST_READ_ACK, ST_READ_NEXT, ST_IGNORE
    } ppb_state_type;

    ppb_state_type      state;
    logic [3:0]         bit_cnt;
    logic [7:0]         shift;
    logic               ack_phase;
    logic               addressed;
    logic               second_select;
    logic [ADDR_W-1:0]  addr_cnt;
    logic [1:0]         ctrl_op;
    logic               all_match;
    logic               ref_done;
    logic [PAGE_COUNT-1:0] prot_bits;
    logic [PROG_CNT_W-1:0] prog_cnt;
    logic               prog_set;
    logic [PAGE_W-1:0]  prog_page;

    wire [PAGE_W-1:0] cur_page  = addr_cnt[ADDR_W-1 -: PAGE_W];
    wire [OFFS_W-1:0] cur_offs  = addr_cnt[OFFS_W-1:0];
    wire [PAGE_W-1:0] next_page = cur_page + 8'h01;
    // the eighth bit is still on the pin when the byte completes
    wire [7:0]        rx_byte   = {shift[6:0], sda_sync[1]};
    wire              byte_in   = scl_rise && bit_cnt == 4'h7;
    wire              sel_match = rx_byte[7:4] == SELECT_ID && rx_byte[3:1] == chip_sel_s;
    wire              sel_write = ~rx_byte[0];
    wire              byte_ok   = {shift[6:0], sda_sync[1]} == page_data_i;
    wire              programming = prog_cnt != '0;
    wire [1:0]        ctrl_code = {shift[0], sda_sync[1]};
    wire              prot_of_wr = prot_bits[write_req_i.addr[ADDR_W-1 -: PAGE_W]];

    // ************************************************************
    // byte shifting and acknowledge cycle on the bus
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || start_seen || stop_seen) begin
            bit_cnt   <= 4'h0;
            ack_phase <= 1'b0;
        end else if (scl_rise && !ack_phase) begin
            shift   <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall && bit_cnt == 4'h8 && !ack_phase) begin
            ack_phase <= 1'b1;
        end else if (scl_fall && ack_phase) begin
            ack_phase <= 1'b0;
            bit_cnt   <= 4'h0;
        end
    end

    // ************************************************************
    // sequence control
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state         <= ST_IDLE;
            addr_cnt      <= '0;
            ctrl_op       <= PROTECT_QUERY;
            addressed     <= 1'b0;
            second_select <= 1'b0;
            all_match     <= 1'b0;
            ref_done      <= 1'b0;
            sda_oe_b_o    <= 1'b1;
            sda_o         <= 1'b0;
            prog_cnt      <= '0;
            prog_set      <= 1'b0;
            prog_page     <= '0;
            prot_bits     <= {PAGE_COUNT{PROT_RESET_VALUE}};
            busy_o        <= 1'b0;
        end else begin
            busy_o <= programming;
            if (programming) begin
                prog_cnt <= prog_cnt - 1'b1;
                if (prog_cnt == PROG_CNT_W'(1)) begin
                    prot_bits[prog_page] <= ~prog_set;
                end
            end
            if (start_seen) begin
                second_select <= addressed;
                addressed     <= 1'b0;
                state         <= ST_SELECT;
                sda_oe_b_o    <= 1'b1;
            end else if (stop_seen) begin
                if (state == ST_REFERENCE && ref_done && all_match && !programming) begin
                    prog_cnt  <= PROG_CNT_W'(PROG_CYCLES);
                    prog_set  <= ctrl_op == PROTECT_SET;
                    prog_page <= cur_page;
                    addr_cnt  <= {cur_page, {OFFS_W{1'b1}}};
                end
                state      <= ST_IDLE;
                addressed  <= 1'b0;
                sda_oe_b_o <= 1'b1;
            end else if (scl_fall && ack_phase) begin
                if (state == ST_QUERY_ACK || state == ST_READ_NEXT) begin
                    // first data bit goes out as the ack clock ends
                    sda_oe_b_o <= prot_bits[cur_page];
                    sda_o      <= 1'b0;
                    state      <= ST_READ_OUT;
                end else begin
                    sda_oe_b_o <= 1'b1;
                end
            end else if (byte_in && !ack_phase) begin
                unique case (state)
                    ST_SELECT: begin
                        // a refused select is not acknowledged, the rest is ignored until START
                        if (sel_match && sel_write && !programming) begin
                            state <= second_select ? ST_CONTROL : ST_ADDR_HI;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                    ST_ADDR_HI: begin
                        addr_cnt[ADDR_W-1:8] <= {shift[3:0], sda_sync[1]};
                        state      <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        addr_cnt[7:0] <= {shift[6:0], sda_sync[1]};
                        addressed     <= 1'b1;
                        state         <= ST_IDLE;
                    end
                    ST_CONTROL: begin
                        ctrl_op   <= ctrl_code;
                        all_match <= 1'b1;
                        ref_done  <= 1'b0;
                        addr_cnt[OFFS_W-1:0] <= '0;
                        state <= (ctrl_code == PROTECT_QUERY) ? ST_QUERY_ACK
                               : (ctrl_code[0] ? ST_REFERENCE : ST_IGNORE);
                    end
                    ST_REFERENCE: begin
                        if (byte_ok && all_match && !ref_done) begin
                            if (cur_offs == {OFFS_W{1'b1}}) begin
                                ref_done <= 1'b1;
                            end else begin
                                addr_cnt[OFFS_W-1:0] <= cur_offs + 1'b1;
                            end
                        end else begin
                            all_match <= 1'b0;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end else if (scl_fall && bit_cnt == 4'h8) begin
                // acknowledge slot: drive low only for accepted bytes; in a read the master answers
                if (state == ST_READ_OUT) begin
                    state <= ST_READ_ACK;
                end
                if ((state == ST_ADDR_LO || state == ST_IDLE && addressed) ||
                    (state == ST_ADDR_HI) || (state == ST_CONTROL) ||
                    (state == ST_REFERENCE && all_match) ||
                    (state == ST_QUERY_ACK)) begin
                    sda_o      <= 1'b0;
                    sda_oe_b_o <= 1'b0;
                end
            end else if (state == ST_READ_ACK && scl_rise) begin
                if (sda_sync[1]) begin
                    state <= ST_IGNORE;
                end else begin
                    addr_cnt <= {next_page, {OFFS_W{1'b0}}};
                    state    <= ST_READ_NEXT;
                end
            end
            if (state == ST_READ_OUT && scl_fall && !ack_phase) begin
                // msb carries the bit, the other seven are released high
                sda_oe_b_o <= 1'b1;
            end
        end
    end

    // ************************************************************
    // normal write gate towards the array
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            array_write_o <= 1'b0;
            array_addr_o  <= '0;
            array_data_o  <= 8'h00;
        end else begin
            array_write_o <= write_req_i.valid && prot_of_wr;
            array_addr_o  <= write_req_i.valid ? write_req_i.addr : addr_cnt;
            array_data_o  <= write_req_i.data;
        end
    end
endmodule

// ==== verification/ppb_chk.sv ====
// concurrent checks on the protection bit path ports
module ppb_chk (
    input wire logic                       core_clk_i,
    input wire logic                       rst_b_i,
    input wire ppb_pkg::ppb_bus_type       bus_i,
    input wire ppb_pkg::ppb_write_type     write_req_i,
    input wire logic                       sda_o,
    input wire logic                       sda_oe_b_o,
    input wire logic [ppb_pkg::ADDR_W-1:0] array_addr_o,
    input wire logic                       array_write_o,
    input wire logic [7:0]                 array_data_o,
    input wire logic                       busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import ppb_pkg::*;
    logic [PROG_CNT_W-1:0] busy_cnt;
    // ************************************************************
    // programming window length, counted here since it is far too long to unroll
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || !busy_o) begin
            busy_cnt <= '0;
        end else begin
            busy_cnt <= busy_cnt + 1'b1;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_bus_idle;
        bus_i.scl && bus_i.sda;
    endsequence
    sequence s_wr_copy;
        array_addr_o == $past(write_req_i.addr) && array_data_o == $past(write_req_i.data);
    endsequence
    AST_DRIVE_ZERO: assert property (!sda_oe_b_o |-> !sda_o) else $error("sda driven high");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_b_o) |-> !bus_i.scl) else $error("sda moved, scl high");
    AST_WR_CAUSE: assert property (array_write_o |-> $past(write_req_i.valid) ##0 s_wr_copy)
        else $error("write without request");
    AST_NO_ACK_BUSY: assert property (busy_o |-> sda_oe_b_o) else $error("ack while programming");
    AST_BUSY_AT_STOP: assert property ($rose(busy_o) |-> s_bus_idle) else $error("programming without stop");
    AST_BUSY_LEN: assert property ($fell(busy_o) |-> busy_cnt <= PROG_CYCLES && busy_cnt + 2 >= PROG_CYCLES)
        else $error("programming time off");
    AST_BUSY_HOLD: assert property (busy_o && busy_cnt + 3 < PROG_CYCLES |=> busy_o) else $error("cut short");
    AST_CNT_CAP: assert property (busy_cnt <= PROG_CYCLES) else $error("programming overran");
endmodule
bind ppb_top ppb_chk chk (.core_clk_i, .rst_b_i, .bus_i, .write_req_i, .sda_o, .sda_oe_b_o,
    .array_addr_o, .array_write_o, .array_data_o, .busy_o);

// ==== verification/ppb_master.sv ====
// two-wire bus master model, one scl period is 8 core clocks (320 ns)
module ppb_master (
    input  wire logic core_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o,
    output logic      res_o,
    output logic      res_bit_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {scl_o, sda_o, res_o, res_bit_o} = 4'hC;
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // ************************************************************
    // bus conditions and bytes; scl idles high between frames
    // ************************************************************
    // a=1,b=0 gives start; a=0,b=1 gives stop
    task automatic cond(input logic a, input logic b);
        tick(1);
        sda_o <= a;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= b;
        tick(4);
        scl_o <= b;
    endtask
    // sample late in scl high, on the falling core edge half a clock before scl drops, so the device's update cannot race it
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            tick(1);
            sda_o <= tx[i];
            tick(3);
            scl_o <= 1'b1;
            tick(3);
            @(negedge core_clk_i) rx[i] = sda_i;
            tick(1);
            scl_o <= 1'b0;
        end
    endtask
    task automatic report(input logic v);
        res_bit_o <= v;
        res_o <= 1'b1;
        tick(1);
        res_o <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] d);
        logic [8:0] rx;
        xfer({d, 1'b1}, rx);
        report(rx[0]);
    endtask
    task automatic rd(input logic ackn);
        logic [8:0] rx;
        xfer({8'hFF, ackn}, rx);
        report(rx[8]);
    endtask
endmodule

// ==== verification/ppb_top_tb_top.sv ====
// self-checking bench for the protection bit path
module ppb_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ppb_pkg::*;
    logic              core_clk = 1'b0;
    logic              rst_b, res, res_bit, m_scl, m_sda, sda_o, sda_oe_b, awrite, busy;
    logic [2:0]        chip_sel;
    ppb_write_type     wreq;
    logic [ADDR_W-1:0] aaddr;
    logic [7:0]        adata;
    logic [7:0]        mem [8192];
    logic              exp_q [$];
    int                mismatches, num_checks, cyc, n;
    wire               sda_w = m_sda & (sda_oe_b | sda_o);
    ppb_master m (.core_clk_i(core_clk), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda), .res_o(res),
        .res_bit_o(res_bit));
    ppb_top dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .bus_i(ppb_bus_type'({m_scl, sda_w})),
        .chip_sel_i(chip_sel), .page_data_i(mem[aaddr]), .write_req_i(wreq), .sda_o(sda_o),
        .sda_oe_b_o(sda_oe_b), .array_addr_o(aaddr), .array_write_o(awrite), .array_data_o(adata),
        .busy_o(busy));
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t ns: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] d, input logic nack);
        exp_q.push_back(nack);
        m.wr(d);
    endtask
    task automatic rd(input logic ackn, input logic msb);
        exp_q.push_back(msb);
        m.rd(ackn);
    endtask
    task automatic head(input logic [7:0] pg, input logic [1:0] code);
        m.cond(1'b1, 1'b0);
        wr({SELECT_ID, chip_sel, 1'b0}, 1'b0);
        wr({3'h0, pg[7:3]}, 1'b0);
        wr({pg[2:0], 5'h00}, 1'b0);
        m.cond(1'b1, 1'b0);
        wr({SELECT_ID, chip_sel, 1'b0}, 1'b0);
        wr({6'($urandom), code}, 1'b0);
    endtask
    task automatic nwrite(input logic [ADDR_W-1:0] a, input logic want);
        @(posedge core_clk);
        wreq <= {1'b1, a, 8'($urandom)};
        @(posedge core_clk);
        wreq.valid <= 1'b0;
        @(negedge core_clk);
        check({7'h0, awrite}, {7'h0, want});
    endtask
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (res) check({7'h0, res_bit}, {7'h0, exp_q.pop_front()});
        if (cyc == 120000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'hC5A4));
        rst_b = 1'b0;
        wreq = '0;
        chip_sel = 3'($urandom);
        foreach (mem[i]) mem[i] = 8'($urandom);
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        // ************************************************************
        // protect the top page, poll while busy, then query and refuse
        // ************************************************************
        head(8'hFF, PROTECT_SET);
        for (int i = 0; i < 32; i++) wr(mem[8160 + i], 1'b0);
        m.cond(1'b0, 1'b1);
        @(negedge core_clk);
        check({7'h0, busy}, 8'h01);
        m.cond(1'b1, 1'b0);
        wr({SELECT_ID, chip_sel, 1'b0}, 1'b1);
        m.cond(1'b0, 1'b1);
        for (n = 0; busy && n < 100010; n++) @(negedge core_clk);
        check({7'h0, n < 100000}, 8'h01);
        check({7'h0, aaddr == 13'h1FFF}, 8'h01);
        nwrite({8'hFF, 5'h07}, 1'b0);
        nwrite({8'hFE, 5'h07}, 1'b1);
        head(8'hFE, PROTECT_QUERY);
        rd(1'b0, 1'b1);
        rd(1'b0, 1'b0);
        rd(1'b1, 1'b1);
        m.cond(1'b0, 1'b1);
        head(8'hFF, PROTECT_CLEAR);
        wr(mem[8160], 1'b0);
        wr(~mem[8161], 1'b1);
        m.cond(1'b0, 1'b1);
        @(negedge core_clk);
        check({7'h0, busy}, 8'h00);
        head(8'hFF, PROTECT_QUERY);
        rd(1'b1, 1'b0);
        m.cond(1'b0, 1'b1);
        repeat (2) @(posedge core_clk);
        summarize();
    end
endmodule
